// ===== core/i2c_reg_slave.sv
// two-wire slave with auto-incrementing register pointer
// assumes bus pins are asynchronous to CLK_I and bus clock is far slower
`timescale 1ns/1ps
`default_nettype none

module i2c_reg_slave #(
	parameter int NUM_REGS = 16,
	parameter int AW = 4,
	parameter logic [NUM_REGS-1:0] RO_MASK = '0
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	input wire logic HW_WE_I,
	input wire logic [AW-1:0] HW_ADDR_I,
	input wire logic [7:0] HW_DATA_I,
	output logic WR_STB_O,
	output logic [7:0] WR_ADDR_O,
	output logic [7:0] WR_DATA_O
);

	// ==========================================================
	// address map helpers
	function automatic logic mapped(input logic [7:0] a);
		mapped = 32'(a) < NUM_REGS;
	endfunction

	function automatic logic writable(input logic [7:0] a);
		writable = mapped(a) && !RO_MASK[a[AW-1:0]];
	endfunction

	// ==========================================================
	// pin synchronisers
	logic scl_m_ff, scl_s_ff, scl_d_ff;
	logic sda_m_ff, sda_s_ff, sda_d_ff;

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			scl_m_ff <= 1'b1;
			scl_s_ff <= 1'b1;
			scl_d_ff <= 1'b1;
			sda_m_ff <= 1'b1;
			sda_s_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_m_ff <= SCL_I;
			scl_s_ff <= scl_m_ff;
			scl_d_ff <= scl_s_ff;
			sda_m_ff <= SDA_I;
			sda_s_ff <= sda_m_ff;
			sda_d_ff <= sda_s_ff;
		end
	end

	wire scl_rise = scl_s_ff && !scl_d_ff;
	wire scl_fall = !scl_s_ff && scl_d_ff;
	wire scl_high = scl_s_ff && scl_d_ff;
	wire start_det = scl_high && sda_d_ff && !sda_s_ff;
	wire stop_det = scl_high && !sda_d_ff && sda_s_ff;

	// ==========================================================
	// protocol state
	i2c_slave_pkg::state_t state_ff, nxt_state;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [7:0] shreg_ff, nxt_shreg;
	logic [7:0] tx_ff, nxt_tx;
	logic [7:0] ptr_ff, nxt_ptr;
	logic rw_ff, nxt_rw;
	logic nack_ff, nxt_nack;
	logic sda_oe_ff, nxt_oe;
	logic bus_we;
	logic load_tx;
	logic [7:0] mem_rdata;

	wire [7:0] rx_shift = {shreg_ff[6:0], sda_s_ff};
	wire byte_end = scl_fall && cnt_ff == i2c_slave_pkg::BYTE_BITS;
	wire addr_hit = shreg_ff[7:1] == i2c_slave_pkg::SLAVE_ADDR;
	wire [7:0] rd_word = mapped(ptr_ff) ? mem_rdata
		: i2c_slave_pkg::READ_ZERO; // [R11]
	wire [7:0] ptr_inc = ptr_ff + 8'h01;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_shreg = shreg_ff;
		nxt_tx = tx_ff;
		nxt_ptr = ptr_ff;
		nxt_rw = rw_ff;
		nxt_nack = nack_ff;
		nxt_oe = sda_oe_ff;
		bus_we = 1'b0;
		load_tx = 1'b0;
		if (start_det) begin
			// repeated start also lands here; pointer is kept
			nxt_state = i2c_slave_pkg::S_ADDR;
			nxt_cnt = i2c_slave_pkg::CNT_RST;
			nxt_oe = 1'b0;
		end else if (stop_det) begin
			nxt_state = i2c_slave_pkg::S_IDLE; // [R3]
			nxt_oe = 1'b0;
		end else begin
			unique case (state_ff)
			i2c_slave_pkg::S_IDLE: begin
			end
			i2c_slave_pkg::S_ADDR: begin
				if (scl_rise) begin
					nxt_shreg = rx_shift;
					nxt_cnt = cnt_ff + 4'h1;
				end else if (byte_end) begin
					if (addr_hit) begin // [R9]
						nxt_rw = shreg_ff[0];
						nxt_oe = 1'b1; // [R10]
						nxt_state = i2c_slave_pkg::S_ADDR_ACK;
					end else begin
						nxt_state = i2c_slave_pkg::S_IDLE;
					end
				end
			end
			i2c_slave_pkg::S_PTR: begin
				if (scl_rise) begin
					nxt_shreg = rx_shift;
					nxt_cnt = cnt_ff + 4'h1;
				end else if (byte_end) begin
					nxt_ptr = shreg_ff; // [R2]
					nxt_oe = 1'b1; // [R10]
					nxt_state = i2c_slave_pkg::S_PTR_ACK;
				end
			end
			i2c_slave_pkg::S_WDATA: begin
				if (scl_rise) begin
					nxt_shreg = rx_shift;
					nxt_cnt = cnt_ff + 4'h1;
				end else if (byte_end) begin
					bus_we = writable(ptr_ff); // [R11]
					nxt_ptr = ptr_inc; // [R4]
					nxt_oe = 1'b1; // [R10]
					nxt_state = i2c_slave_pkg::S_WDATA_ACK;
				end
			end
			i2c_slave_pkg::S_ADDR_ACK: begin
				if (scl_fall) begin
					nxt_cnt = i2c_slave_pkg::CNT_RST;
					if (rw_ff) begin
						load_tx = 1'b1;
						nxt_tx = {rd_word[6:0], 1'b0};
						nxt_oe = !rd_word[7];
						nxt_ptr = ptr_inc; // [R5]
						nxt_state = i2c_slave_pkg::S_RDATA;
					end else begin
						nxt_oe = 1'b0;
						nxt_state = i2c_slave_pkg::S_PTR;
					end
				end
			end
			i2c_slave_pkg::S_PTR_ACK, i2c_slave_pkg::S_WDATA_ACK: begin
				if (scl_fall) begin
					nxt_oe = 1'b0;
					nxt_cnt = i2c_slave_pkg::CNT_RST;
					nxt_state = i2c_slave_pkg::S_WDATA; // [R4]
				end
			end
			i2c_slave_pkg::S_RDATA: begin
				if (scl_rise) begin
					nxt_cnt = cnt_ff + 4'h1;
				end else if (byte_end) begin
					// let the master drive its acknowledge
					nxt_oe = 1'b0;
					nxt_state = i2c_slave_pkg::S_RDATA_ACK;
				end else if (scl_fall) begin
					nxt_oe = !tx_ff[7];
					nxt_tx = {tx_ff[6:0], 1'b0};
				end
			end
			i2c_slave_pkg::S_RDATA_ACK: begin
				if (scl_rise) begin
					nxt_nack = sda_s_ff;
				end else if (scl_fall) begin
					if (nack_ff) begin
						nxt_state = i2c_slave_pkg::S_IDLE; // [R7]
					end else begin
						load_tx = 1'b1;
						nxt_tx = {rd_word[6:0], 1'b0};
						nxt_oe = !rd_word[7];
						nxt_ptr = ptr_inc; // [R5]
						nxt_cnt = i2c_slave_pkg::CNT_RST;
						nxt_state = i2c_slave_pkg::S_RDATA;
					end
				end
			end
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			state_ff <= i2c_slave_pkg::S_IDLE;
			cnt_ff <= i2c_slave_pkg::CNT_RST;
			shreg_ff <= i2c_slave_pkg::DATA_RST;
			tx_ff <= i2c_slave_pkg::DATA_RST;
			ptr_ff <= i2c_slave_pkg::PTR_RST;
			rw_ff <= 1'b0;
			nack_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			shreg_ff <= nxt_shreg;
			tx_ff <= nxt_tx;
			ptr_ff <= nxt_ptr;
			rw_ff <= nxt_rw;
			nack_ff <= nxt_nack;
			sda_oe_ff <= nxt_oe;
		end
	end

	// ==========================================================
	// storage and user-side write report
	reg_store #(
		.DEPTH(NUM_REGS),
		.AW(AW),
		.DW(8)
	) u_store (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.bus_we_i(bus_we),
		.bus_addr_i(ptr_ff[AW-1:0]),
		.bus_data_i(shreg_ff),
		.hw_we_i(HW_WE_I),
		.hw_addr_i(HW_ADDR_I),
		.hw_data_i(HW_DATA_I),
		.rd_addr_i(ptr_ff[AW-1:0]),
		.rd_data_o(mem_rdata)
	);

	logic wr_stb_ff;
	logic [7:0] wr_addr_ff, wr_data_ff;

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			wr_stb_ff <= 1'b0;
			wr_addr_ff <= i2c_slave_pkg::PTR_RST;
			wr_data_ff <= i2c_slave_pkg::DATA_RST;
		end else begin
			wr_stb_ff <= bus_we;
			if (bus_we) begin
				wr_addr_ff <= ptr_ff;
				wr_data_ff <= shreg_ff;
			end
		end
	end

	// open drain: the pad only ever pulls low
	assign SDA_O = 1'b0;
	assign SDA_OE_O = sda_oe_ff;
	assign WR_STB_O = wr_stb_ff;
	assign WR_ADDR_O = wr_addr_ff;
	assign WR_DATA_O = wr_data_ff;

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	a_ptr_load: assert property ( // [R2]
		state_ff == i2c_slave_pkg::S_PTR && byte_end && !start_det
		&& !stop_det |=> ptr_ff == $past(shreg_ff)
	) else $error("pointer byte not latched");

	a_stop_no_write: assert property ( // [R3]
		stop_det && (state_ff == i2c_slave_pkg::S_PTR_ACK
		|| state_ff == i2c_slave_pkg::S_WDATA)
		|=> $stable(ptr_ff) && !wr_stb_ff ##1 !wr_stb_ff
	) else $error("stop after pointer caused a write");

	a_write_incr: assert property ( // [R4]
		bus_we |=> wr_stb_ff && wr_addr_ff == $past(ptr_ff)
		&& ptr_ff == wr_addr_ff + 8'h01
	) else $error("write address or pointer step wrong");

	a_read_incr: assert property ( // [R5]
		load_tx |=> ptr_ff == $past(ptr_ff) + 8'h01
		&& sda_oe_ff == !$past(rd_word[7])
	) else $error("read did not advance pointer");

	a_nack_release: assert property ( // [R7]
		state_ff == i2c_slave_pkg::S_RDATA_ACK && scl_fall && nack_ff
		&& !start_det && !stop_det
		|=> state_ff == i2c_slave_pkg::S_IDLE && !sda_oe_ff
	) else $error("data still driven after nack");

	a_addr_miss: assert property ( // [R9]
		state_ff == i2c_slave_pkg::S_ADDR && byte_end && !addr_hit
		&& !start_det && !stop_det
		|=> state_ff == i2c_slave_pkg::S_IDLE && !sda_oe_ff
	) else $error("foreign address acknowledged");

	a_ack_drive: assert property ( // [R10]
		state_ff inside {i2c_slave_pkg::S_ADDR_ACK,
		i2c_slave_pkg::S_PTR_ACK, i2c_slave_pkg::S_WDATA_ACK}
		|-> sda_oe_ff
	) else $error("acknowledge not driven");

	a_ro_ignored: assert property ( // [R11]
		state_ff == i2c_slave_pkg::S_WDATA && byte_end && !start_det
		&& !stop_det && (32'(ptr_ff) >= NUM_REGS
		|| RO_MASK[ptr_ff[AW-1:0]]) |=> !wr_stb_ff
	) else $error("write to protected register");

	a_unmapped_zero: assert property ( // [R11]
		load_tx && !mapped(ptr_ff) |=> tx_ff == 8'h00 && sda_oe_ff
	) else $error("unmapped read not zero");

	c_write: cover property (bus_we);
	c_read_two: cover property (load_tx ##[1:1000] load_tx);
	c_nack_end: cover property (
		state_ff == i2c_slave_pkg::S_RDATA_ACK ##1
		state_ff == i2c_slave_pkg::S_IDLE);

endmodule

`default_nettype wire

// ===== inc/i2c_slave_pkg.sv
// constants and types shared by the two-wire register access slave
// assumes a single system clock; bus pins are sampled, not used as clocks
//
// Contract
// R1 - master writes: address with direction low, then at least one byte
// R2 - first byte after write address loads the register pointer
// R3 - stop right after pointer byte only stores pointer, writes nothing
// R4 - later write bytes fill pointed register, pointer increments each byte
// R5 - reads return pointed register, pointer increments after every sent byte
// R6 - master loads pointer by write, then repeated start and reads
// R7 - master nack ends read; device stops driving data line
// R8 - after suspend, master issues stop before any new traffic
// R9 - answer only fixed seven-bit address; direction bit selects read/write
// R10 - ninth clock is acknowledge; receiver pulls data line low
// R11 - unmapped or read-only writes acked but ignored; unmapped reads zero
`default_nettype none

package i2c_slave_pkg;

	// ==========================================================
	// bus constants
	localparam logic [6:0] SLAVE_ADDR = 7'h35;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] CNT_RST = 4'h0;

	// ==========================================================
	// reset values and unmapped read value
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// ==========================================================
	// protocol states
	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_ADDR = 9'h002,
		S_ADDR_ACK = 9'h004,
		S_PTR = 9'h008,
		S_PTR_ACK = 9'h010,
		S_WDATA = 9'h020,
		S_WDATA_ACK = 9'h040,
		S_RDATA = 9'h080,
		S_RDATA_ACK = 9'h100
	} state_t;

endpackage

`default_nettype wire

// ===== core/reg_store.sv
// register storage of the slave: two write ports, registered read
// assumes both write ports sit on the system clock
`timescale 1ns/1ps
`default_nettype none

module reg_store #(
	parameter int DEPTH = 16,
	parameter int AW = 4,
	parameter int DW = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic bus_we_i,
	input wire logic [AW-1:0] bus_addr_i,
	input wire logic [DW-1:0] bus_data_i,
	input wire logic hw_we_i,
	input wire logic [AW-1:0] hw_addr_i,
	input wire logic [DW-1:0] hw_data_i,
	input wire logic [AW-1:0] rd_addr_i,
	output logic [DW-1:0] rd_data_o
);

	logic [DW-1:0] mem_ff [DEPTH];

	// ==========================================================
	// storage; the bus port wins if both hit one word
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (rst_i) begin
				mem_ff[i] <= '0;
			end else if (bus_we_i && bus_addr_i == AW'(i)) begin
				mem_ff[i] <= bus_data_i;
			end else if (hw_we_i && hw_addr_i == AW'(i)) begin
				mem_ff[i] <= hw_data_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_data_o <= '0;
		end else begin
			rd_data_o <= mem_ff[rd_addr_i];
		end
	end

endmodule

`default_nettype wire

// ===== tb/bus_master.sv
// two-wire bus master model driving the slave's clock and data pins
// assumes a pull-up on the data wire; resolved level comes back on sda_i
`timescale 1ns/1ps
`default_nettype none

module bus_master (
	input wire logic lclk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// ==========================================================
	// bus phases
	// four link clocks per phase keeps scl half period far above 8 clk
	task automatic tick;
		repeat (4) @(negedge lclk_i);
	endtask

	// start and repeated start alike
	task automatic start;
		sda_o = 1'b1;
		tick;
		scl_o = 1'b1;
		tick;
		sda_o = 1'b0;
		tick;
		scl_o = 1'b0;
		tick;
	endtask

	task automatic stop;
		sda_o = 1'b0;
		tick;
		scl_o = 1'b1;
		tick;
		sda_o = 1'b1;
		tick;
	endtask

	// eight bits msb first, then the ninth clock carrying last
	task automatic xfer(input logic [7:0] d, input logic last,
		output logic [7:0] q, output logic a);
		for (int i = 8; i >= 0; i--) begin
			sda_o = (i == 0) ? last : d[i-1];
			tick;
			scl_o = 1'b1;
			tick;
			if (i == 0)
				a = sda_i;
			else
				q[i-1] = sda_i;
			tick;
			scl_o = 1'b0;
			tick;
		end
		// data line keeps the ninth-bit level; the next phase sets it
	endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench of the register access slave
// assumes bus_master for the far side; link clock unrelated to CLK_I
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic CLK_I = 1'b0;
	logic RST_I = 1'b1;
	logic lclk = 1'b0;
	logic HW_WE_I = 1'b0;
	logic [3:0] HW_ADDR_I = 4'h0;
	logic [7:0] HW_DATA_I = 8'h00;
	wire scl, sda_m, SDA_O, SDA_OE_O, WR_STB_O;
	wire [7:0] WR_ADDR_O, WR_DATA_O;
	wire sda = sda_m & ~(SDA_OE_O & ~SDA_O);
	int n_mismatch = 0;
	int n_tests = 0;
	int strobes = 0;
	logic [7:0] l_addr = 8'h00;
	logic [7:0] l_data = 8'h00;

	always #5 CLK_I = ~CLK_I;
	initial begin
		#7;
		forever #16 lclk = ~lclk;
	end

	i2c_reg_slave #(.NUM_REGS(16), .AW(4), .RO_MASK(16'h0002))
	i2c_reg_slave_inst (.CLK_I(CLK_I), .RST_I(RST_I), .SCL_I(scl),
		.SDA_I(sda), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
		.HW_WE_I(HW_WE_I), .HW_ADDR_I(HW_ADDR_I), .HW_DATA_I(HW_DATA_I),
		.WR_STB_O(WR_STB_O), .WR_ADDR_O(WR_ADDR_O), .WR_DATA_O(WR_DATA_O));
	bus_master bus_master_inst (.lclk_i(lclk), .sda_i(sda), .scl_o(scl),
		.sda_o(sda_m));

	// sampled mid-cycle so the strobe is seen settled, once
	always @(negedge CLK_I) begin
		if (WR_STB_O === 1'b1) begin
			strobes++;
			l_addr = WR_ADDR_O;
			l_data = WR_DATA_O;
		end
	end

	// ==========================================================
	// helpers
	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wb(input logic [7:0] d, input string what);
		logic [7:0] q;
		logic a;
		bus_master_inst.xfer(d, 1'b1, q, a);
		check(what, 8'h00, {7'h00, a});
	endtask

	task automatic rb(input logic nack, input logic [7:0] exp);
		logic [7:0] q;
		logic a;
		bus_master_inst.xfer(8'hff, nack, q, a);
		check("read data", exp, q);
	endtask

	// pointer write then repeated start into read
	task automatic rd_at(input logic [7:0] p);
		bus_master_inst.start;
		wb(8'h6a, "addr ack");
		wb(p, "ptr ack");
		bus_master_inst.start;
		wb(8'h6b, "read addr ack");
	endtask

	task automatic finish_read;
		check("oe after nack", 8'h00, {7'h00, SDA_OE_O});
		bus_master_inst.stop;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_write_read;
		int s0 = strobes;
		bus_master_inst.start;
		wb(8'h6a, "addr ack");
		wb(8'h02, "ptr ack");
		wb(8'hab, "data ack");
		check("wr addr", 8'h02, l_addr);
		check("wr data", 8'hab, l_data);
		wb(8'hcd, "data ack");
		check("wr addr", 8'h03, l_addr);
		check("wr data", 8'hcd, l_data);
		bus_master_inst.stop;
		check("strobes", 8'h02, 8'(strobes - s0));
		rd_at(8'h02);
		rb(1'b0, 8'hab);
		rb(1'b1, 8'hcd);
		finish_read;
		$display("test write_read done");
	endtask

	task automatic t_ptr_only;
		int s0 = strobes;
		bus_master_inst.start;
		wb(8'h6a, "addr ack");
		wb(8'h02, "ptr ack");
		bus_master_inst.stop;
		check("strobes", 8'h00, 8'(strobes - s0));
		bus_master_inst.start;
		wb(8'h6b, "read addr ack");
		rb(1'b1, 8'hab);
		finish_read;
		$display("test ptr_only done");
	endtask

	task automatic t_wrong_addr;
		logic [7:0] bad [2] = '{8'h6c, 8'h68};
		logic [7:0] q;
		logic a;
		foreach (bad[i]) begin
			bus_master_inst.start;
			bus_master_inst.xfer(bad[i], 1'b1, q, a);
			check("foreign addr nack", 8'h01, {7'h00, a});
			bus_master_inst.stop;
		end
		$display("test wrong_addr done");
	endtask

	task automatic t_protected;
		int s0 = strobes;
		@(negedge CLK_I);
		HW_WE_I = 1'b1;
		HW_ADDR_I = 4'h1;
		HW_DATA_I = 8'h5a;
		@(negedge CLK_I);
		HW_WE_I = 1'b0;
		bus_master_inst.start;
		wb(8'h6a, "addr ack");
		wb(8'h01, "ptr ack");
		wb(8'h11, "ro data ack");
		bus_master_inst.start;
		wb(8'h6a, "addr ack");
		wb(8'h20, "ptr ack");
		wb(8'h99, "unmapped data ack");
		bus_master_inst.stop;
		check("strobes", 8'h00, 8'(strobes - s0));
		rd_at(8'h01);
		rb(1'b0, 8'h5a);
		rb(1'b1, 8'hab);
		finish_read;
		rd_at(8'h20);
		rb(1'b1, 8'h00);
		finish_read;
		$display("test protected done");
	endtask

	// ==========================================================
	// run
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge CLK_I);
		n_mismatch++;
		$display("mismatch watchdog expected done seen hang");
		tally_and_finish;
	end

	initial begin
		repeat (16) @(negedge CLK_I);
		RST_I = 1'b0;
		repeat (4) @(negedge CLK_I);
		// stop first, as after a bus suspend
		bus_master_inst.stop;
		t_write_read;
		t_ptr_only;
		t_wrong_addr;
		t_protected;
		tally_and_finish;
	end
endmodule
`default_nettype wire
